// ---- rtl/buck_channel_pwm.sv ----
// Four-channel buck timing: time base, oscillator model, PWM, fault and good.
// Assumes configuration and measurements are stable on clk; host logic holds
// the register contents and pulses overcurrent_clear to clear fault flags.
`timescale 1ns/100ps
module buck_channel_pwm
  import buck_seq_pkg::*;
#(
  parameter int CYC_US  = CYC_PER_US,
  parameter int OC_WAIT = OC_WAIT_Q
)(
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic [3:0]      channel_enable,
  input  wire logic [3:0][15:0] channel_rise_profile,
  input  wire logic [3:0][15:0] channel_fall_profile,
  input  wire logic [7:0]      switching_clock_select,
  input  wire logic [3:0][7:0] good_window_upper,
  input  wire logic [3:0][7:0] good_window_lower,
  input  wire logic [3:0][7:0] good_assert_delay,
  input  wire logic [3:0][7:0] channel_duty_cap,
  input  wire logic [7:0]      follower_map_low,
  input  wire logic [7:0]      follower_map_high,
  input  wire logic [3:0][7:0] current_limit_setting,
  input  wire logic [3:0][7:0] vout_target,
  input  wire logic [3:0][7:0] discharge_level,
  input  wire logic [3:0][7:0] duty_demand,
  input  wire logic [3:0][7:0] vout_sense,
  input  wire logic [3:0][7:0] current_sense,
  input  wire logic [3:0]      overcurrent_clear,
  output logic      [3:0]      gate_high,
  output logic      [3:0]      gate_low,
  output logic      [3:0]      power_good,
  output logic      [3:0]      overcurrent_status,
  output logic      [3:0][7:0] channel_ref
);

  typedef struct packed {
    logic [15:0]     us_cnt;
    logic [7:0]      q_cnt;
    logic            us_tick;
    logic            q_tick;
    logic [9:0]      acc;
    logic            tick;
    logic [7:0]      cnt;
    logic [3:0]      gh;
    logic [3:0]      gl;
    logic [3:0]      pg;
    logic [3:0]      ocf;
    logic [3:0][7:0] pgd;
  } pwm_state_t;

  pwm_state_t s;
  pwm_state_t next_s;

  logic [2:0]       osc_code;
  logic [2:0]       div_code;
  logic [9:0]       osc_inc;
  logic [10:0]      acc_sum;
  logic [7:0]       period;
  logic [7:0]       max_on;
  logic [7:0]       min_on;
  logic [15:0]      follow;
  logic [3:0]       run;
  logic [3:0]       ss_done;
  logic [3:0]       oc_event;
  logic [3:0]       trip;
  logic [3:0]       inwin;
  logic [3:0][15:0] dem_prod;
  logic [3:0][15:0] cap_prod;
  logic [3:0][7:0]  cap_on;
  logic [3:0][7:0]  on_ticks;

  assign osc_code = switching_clock_select[OSC_MSB:OSC_LSB];
  assign div_code = switching_clock_select[DIV_MSB:DIV_LSB];

  // Oscillator rate as a fractional tick enable on clk
  assign osc_inc = 10'(OSC_BASE_DMHZ - OSC_STEP_DMHZ * int'(osc_code));
  assign acc_sum = {1'b0, s.acc} + {1'b0, osc_inc};

  assign period = 8'(PERIOD_UNIT * (int'(div_code) + 1));
  assign max_on = period - 8'(SAMPLE_TICKS);
  assign min_on = min_on_ticks(osc_code);

  assign follow = {follower_map_high, follower_map_low};

  // Demand and cap are fractions of 256 of the period
  function automatic logic [7:0] clamp_on(
    input logic [7:0] raw,
    input logic [7:0] cap,
    input logic [7:0] top,
    input logic [7:0] least
  );
    logic [7:0] v;
    v = raw;
    if (v > cap)
      v = cap;
    if (v > top)
      v = top;
    if (v != 8'h00 && v < least)
      v = least;
    return v;
  endfunction

  // Each channel runs its own sequencer with private counters
  for (genvar g = 0; g < 4; g++)
  begin : g_ch
    assign oc_event[g] = run[g] &&
      (current_sense[g] > {2'b00, current_limit_setting[g][LIMIT_MSB:LIMIT_LSB]});
    assign trip[g] = oc_event[g] ||
      |(oc_event & {follow[12 + g], follow[8 + g], follow[4 + g], follow[g]});
    assign inwin[g] = vout_sense[g] >= good_window_lower[g] &&
      vout_sense[g] <= good_window_upper[g];
    assign dem_prod[g] = 16'(duty_demand[g]) * 16'(period);
    assign cap_prod[g] = 16'(channel_duty_cap[g]) * 16'(period);
    assign cap_on[g]   = cap_prod[g][15:8];
    assign on_ticks[g] = clamp_on(dem_prod[g][15:8], cap_on[g], max_on, min_on);

    channel_sequencer #(
      .OC_WAIT (OC_WAIT)
    ) channel_sequencer_inst (
      .clk       (clk),
      .rst_b     (rst_b),
      .enable    (channel_enable[g]),
      .trip      (trip[g]),
      .us_tick   (s.us_tick),
      .q_tick    (s.q_tick),
      .rise      (channel_rise_profile[g]),
      .fall      (channel_fall_profile[g]),
      .target    (vout_target[g]),
      .discharge (discharge_level[g]),
      .ref_level (channel_ref[g]),
      .run       (run[g]),
      .ss_done   (ss_done[g])
    );
  end

  always_comb
  begin
    next_s = s;
    next_s.us_tick = 1'b0;
    next_s.q_tick  = 1'b0;
    if (s.us_cnt == 16'(CYC_US - 1))
    begin
      next_s.us_cnt  = '0;
      next_s.us_tick = 1'b1;
      if (s.q_cnt == 8'(QUARTER_US - 1))
      begin
        next_s.q_cnt  = '0;
        next_s.q_tick = 1'b1;
      end
      else
        next_s.q_cnt = s.q_cnt + 8'd1;
    end
    else
      next_s.us_cnt = s.us_cnt + 16'd1;

    if (acc_sum >= 11'(CLK_DMHZ))
    begin
      next_s.acc  = 10'(acc_sum - 11'(CLK_DMHZ));
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.acc  = acc_sum[9:0];
      next_s.tick = 1'b0;
    end

    // A shortened period after a select change wraps at once
    if (s.tick)
    begin
      if (s.cnt >= period - 8'd1)
        next_s.cnt = '0;
      else
        next_s.cnt = s.cnt + 8'd1;
    end

    for (int c = 0; c < 4; c++)
    begin
      // Trip gates the drive in the same cycle, ahead of the sequencer
      next_s.gh[c] = run[c] && !trip[c] && div_code != 3'b000 &&
        s.cnt < on_ticks[c];
      next_s.gl[c] = run[c] && !trip[c] && div_code != 3'b000 &&
        !(s.cnt < on_ticks[c]);
      // Set wins over a clear in the same cycle
      next_s.ocf[c] = (s.ocf[c] && !overcurrent_clear[c]) || oc_event[c];
      if (!ss_done[c] || !inwin[c])
      begin
        next_s.pgd[c] = '0;
        next_s.pg[c]  = 1'b0;
      end
      else if (s.pgd[c] == good_assert_delay[c])
        next_s.pg[c] = 1'b1;
      else if (s.q_tick)
        next_s.pgd[c] = s.pgd[c] + 8'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign gate_high          = s.gh;
  assign gate_low           = s.gl;
  assign power_good         = s.pg;
  assign overcurrent_status = s.ocf;

  chk_trip_gate_off: assert property (@(posedge clk) disable iff (!rst_b)
    trip != 4'h0 |=> (gate_high & $past(trip)) == 4'h0) else $error("drive on after trip");
  chk_fault_flag: assert property (@(posedge clk) disable iff (!rst_b)
    oc_event != 4'h0 |=> (overcurrent_status & $past(oc_event)) == $past(oc_event))
    else $error("fault flag not set");
  chk_follow_trip: assert property (@(posedge clk) disable iff (!rst_b)
    oc_event[0] && follower_map_low[1] |=> !gate_high[1]) else $error("follower kept driving");
  chk_limit_compare: assert property (@(posedge clk) disable iff (!rst_b)
    run[0] && current_sense[0] > {2'b00, current_limit_setting[0][LIMIT_MSB:LIMIT_LSB]}
    |=> overcurrent_status[0] && !gate_high[0]) else $error("limit not enforced");
  chk_min_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(gate_high[0]) |=> gate_high[0] || $past(trip[0]) || !$past(run[0]))
    else $error("high-side pulse too short");
  chk_low_reserve: assert property (@(posedge clk) disable iff (!rst_b)
    gate_high[0] |-> $past(s.cnt) < $past(period) - 8'(SAMPLE_TICKS))
    else $error("sampling interval violated");
  chk_duty_clamp: assert property (@(posedge clk) disable iff (!rst_b)
    gate_high[1] && $past(cap_on[1]) >= $past(min_on) |-> $past(s.cnt) < $past(cap_on[1]))
    else $error("duty cap exceeded");
  chk_div_off: assert property (@(posedge clk) disable iff (!rst_b)
    div_code == 3'b000 |=> gate_high == 4'h0 && gate_low == 4'h0)
    else $error("switching with divider zero");
  chk_good_window: assert property (@(posedge clk) disable iff (!rst_b)
    power_good[0] |-> $past(inwin[0])) else $error("good outside window");
  chk_good_after_ss: assert property (@(posedge clk) disable iff (!rst_b)
    power_good[0] |-> $past(ss_done[0]) && $past(s.pgd[0]) == $past(good_assert_delay[0]))
    else $error("good before soft-start and delay");

  cov_good_high: cover property (@(posedge clk) disable iff (!rst_b) $rose(power_good[0]));
  cov_fault_set: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(overcurrent_status[0]));
  cov_follow: cover property (@(posedge clk) disable iff (!rst_b)
    oc_event[0] && trip[1] && !oc_event[1]);

endmodule

// ---- rtl/buck_seq_pkg.sv ----
// Constants, types and helpers for the four-channel buck sequencer and PWM.
// Assumes a 50 MHz system clock and that measurements arrive on that clock.
// Behaviour
// - Over-current turns that channel's gate drives off.
// - After over-current, wait 200 ms, then soft-start.
// - Over-current also restarts channels marked as followers.
// - Over-current sets the channel's sticky fault flag.
// - Start delay of rise[15:10] quarter-milliseconds before pulses.
// - Start ramp: 50 mV step per rise[9:0] us.
// - Stop delay of fall[15:10] quarter-milliseconds before ramping.
// - Stop ramp: 50 mV step per fall[9:0] us.
// - Output compared with upper, lower 20 mV bounds.
// - Power good high while output lies inside window.
// - Power-good delay counts only after soft-start completes.
// - Pre-charged output gets no power good before soft-start.
// - Oscillator 48 MHz, less 3.2 MHz per code.
// - Period 16 times divider plus one; zero unsupported.
// - High-side pulses never shorter than 40 ns.
// - Reserve 16 oscillator ticks low-side each period.
// - Clamp duty at the programmed channel duty cap, or at minimum on time if the cap lies below it.
// - Trip when sensed current exceeds limit bits [5:0].
package buck_seq_pkg;

  localparam int CLK_MHZ       = 50;
  localparam int CLK_PERIOD_NS = 20;
  localparam int NS_PER_US     = 1000;
  localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
  localparam int QUARTER_US    = 250;
  localparam int OC_TIMEOUT_MS = 200;
  localparam int OC_WAIT_Q     = OC_TIMEOUT_MS * 1000 / QUARTER_US;

  localparam int DLY_MSB   = 15;
  localparam int DLY_LSB   = 10;
  localparam int HOLD_MSB  = 9;
  localparam int HOLD_LSB  = 0;
  localparam int OSC_MSB   = 6;
  localparam int OSC_LSB   = 4;
  localparam int DIV_MSB   = 2;
  localparam int DIV_LSB   = 0;
  localparam int LIMIT_MSB = 5;
  localparam int LIMIT_LSB = 0;

  // Oscillator rates in units of 0.1 MHz
  localparam int OSC_BASE_DMHZ = 480;
  localparam int OSC_STEP_DMHZ = 32;
  localparam int CLK_DMHZ      = CLK_MHZ * 10;
  localparam int PERIOD_UNIT   = 16;
  localparam int SAMPLE_TICKS  = 16;
  localparam int MIN_ON_NS     = 40;

  localparam logic [7:0] REF_RESET = 8'h00;

  typedef enum logic [2:0] {
    SEQ_OFF     = 3'b000,
    SEQ_SS_DLY  = 3'b001,
    SEQ_RAMP_UP = 3'b010,
    SEQ_ON      = 3'b011,
    SEQ_SD_DLY  = 3'b100,
    SEQ_RAMP_DN = 3'b101,
    SEQ_OC_WAIT = 3'b110
  } seq_t;

  // Least whole oscillator ticks covering the minimum on time
  function automatic logic [7:0] min_on_ticks(input logic [2:0] code);
    int f;
    f = OSC_BASE_DMHZ - OSC_STEP_DMHZ * int'(code);
    return 8'((MIN_ON_NS * f + NS_PER_US * 10 - 1) / (NS_PER_US * 10));
  endfunction

endpackage

// ---- rtl/channel_sequencer.sv ----
// One channel's soft-start, soft-stop and over-current restart sequencer.
// Assumes one-cycle microsecond and quarter-millisecond ticks from the top.
`timescale 1ns/100ps
module channel_sequencer
  import buck_seq_pkg::*;
#(
  parameter int OC_WAIT = OC_WAIT_Q
)(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        enable,
  input  wire logic        trip,
  input  wire logic        us_tick,
  input  wire logic        q_tick,
  input  wire logic [15:0] rise,
  input  wire logic [15:0] fall,
  input  wire logic [7:0]  target,
  input  wire logic [7:0]  discharge,
  output logic      [7:0]  ref_level,
  output logic             run,
  output logic             ss_done
);

  typedef struct packed {
    seq_t       st;
    logic [9:0] dly;
    logic [9:0] step;
    logic [7:0] ref_v;
    logic       run;
    logic       done;
  } seq_state_t;

  seq_state_t s;
  seq_state_t next_s;

  always_comb
  begin
    next_s = s;
    unique case (s.st)
      SEQ_OFF:
      begin
        next_s.run   = 1'b0;
        next_s.done  = 1'b0;
        next_s.ref_v = REF_RESET;
        if (enable)
        begin
          next_s.st  = SEQ_SS_DLY;
          next_s.dly = '0;
        end
      end
      SEQ_SS_DLY:
      begin
        if (10'(rise[DLY_MSB:DLY_LSB]) == s.dly)
        begin
          next_s.st   = SEQ_RAMP_UP;
          next_s.step = '0;
          next_s.run  = 1'b1;
        end
        else if (q_tick)
          next_s.dly = s.dly + 10'd1;
      end
      SEQ_RAMP_UP:
      begin
        if (!enable)
        begin
          next_s.st  = SEQ_SD_DLY;
          next_s.dly = '0;
        end
        else if (s.ref_v >= target)
        begin
          next_s.st   = SEQ_ON;
          next_s.done = 1'b1;
        end
        else if (us_tick)
        begin
          if ({1'b0, s.step} + 11'd1 >= {1'b0, rise[HOLD_MSB:HOLD_LSB]})
          begin
            next_s.ref_v = s.ref_v + 8'd1;
            next_s.step  = '0;
          end
          else
            next_s.step = s.step + 10'd1;
        end
      end
      SEQ_ON:
      begin
        if (!enable)
        begin
          next_s.st   = SEQ_SD_DLY;
          next_s.dly  = '0;
          next_s.done = 1'b0;
        end
      end
      SEQ_SD_DLY:
      begin
        if (10'(fall[DLY_MSB:DLY_LSB]) == s.dly)
        begin
          next_s.st   = SEQ_RAMP_DN;
          next_s.step = '0;
        end
        else if (q_tick)
          next_s.dly = s.dly + 10'd1;
      end
      SEQ_RAMP_DN:
      begin
        if (s.ref_v <= discharge)
        begin
          next_s.st    = SEQ_OFF;
          next_s.run   = 1'b0;
          next_s.ref_v = REF_RESET;
        end
        else if (us_tick)
        begin
          if ({1'b0, s.step} + 11'd1 >= {1'b0, fall[HOLD_MSB:HOLD_LSB]})
          begin
            next_s.ref_v = s.ref_v - 8'd1;
            next_s.step  = '0;
          end
          else
            next_s.step = s.step + 10'd1;
        end
      end
      SEQ_OC_WAIT:
      begin
        if (q_tick)
        begin
          if (s.dly == 10'(OC_WAIT - 1))
          begin
            next_s.st  = enable ? SEQ_SS_DLY : SEQ_OFF;
            next_s.dly = '0;
          end
          else
            next_s.dly = s.dly + 10'd1;
        end
      end
      default:
      begin
        next_s.st  = SEQ_OFF;
        next_s.run = 1'b0;
      end
    endcase
    // An idle channel ignores a follower trip; nothing to restart
    if (trip && s.st != SEQ_OFF && s.st != SEQ_OC_WAIT)
    begin
      next_s.st    = SEQ_OC_WAIT;
      next_s.run   = 1'b0;
      next_s.done  = 1'b0;
      next_s.dly   = '0;
      next_s.ref_v = REF_RESET;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '{st: SEQ_OFF, dly: '0, step: '0, ref_v: REF_RESET, run: 1'b0, done: 1'b0};
    else
      s <= next_s;
  end

  assign ref_level = s.ref_v;
  assign run       = s.run;
  assign ss_done   = s.done;

  chk_wait_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    s.st == SEQ_OC_WAIT |-> !s.run) else $error("pulses allowed during fault wait");
  chk_wait_restart: assert property (@(posedge clk) disable iff (!rst_b)
    s.st == SEQ_OC_WAIT && q_tick && s.dly == 10'(OC_WAIT - 1) && enable && !trip
    |=> s.st == SEQ_SS_DLY) else $error("no restart after fault wait");
  chk_start_delay: assert property (@(posedge clk) disable iff (!rst_b)
    s.st == SEQ_RAMP_UP && $past(s.st) == SEQ_SS_DLY
    |-> $past(s.dly) == 10'($past(rise[DLY_MSB:DLY_LSB]))) else $error("start delay wrong");
  chk_stop_delay: assert property (@(posedge clk) disable iff (!rst_b)
    s.st == SEQ_RAMP_DN && $past(s.st) == SEQ_SD_DLY
    |-> $past(s.dly) == 10'($past(fall[DLY_MSB:DLY_LSB]))) else $error("stop delay wrong");
  chk_rise_step: assert property (@(posedge clk) disable iff (!rst_b)
    s.st == SEQ_RAMP_UP && $past(s.st) == SEQ_RAMP_UP && s.ref_v != $past(s.ref_v)
    |-> s.ref_v == $past(s.ref_v) + 8'd1) else $error("rise step not one unit");
  chk_fall_step: assert property (@(posedge clk) disable iff (!rst_b)
    s.st == SEQ_RAMP_DN && $past(s.st) == SEQ_RAMP_DN && s.ref_v != $past(s.ref_v)
    |-> s.ref_v == $past(s.ref_v) - 8'd1) else $error("fall step not one unit");
  chk_stop_end: assert property (@(posedge clk) disable iff (!rst_b)
    $past(s.st) == SEQ_RAMP_DN && s.st == SEQ_OFF |-> !s.run) else $error("pulses after stop");
  cov_stop_done: cover property (@(posedge clk) disable iff (!rst_b)
    $past(s.st) == SEQ_RAMP_DN && s.st == SEQ_OFF);

endmodule

// ---- tb/power_stage_model.sv ----
// Behavioural power stage behind the four high/low gate drive pairs.
// Assumes registered gate drives on clk; the bench sets each load current.
`timescale 1ns/100ps
module power_stage_model
(
  input  wire logic [3:0]      gate_high,
  input  wire logic [3:0]      gate_low,
  input  wire logic [3:0][7:0] channel_ref,
  input  wire logic [3:0][7:0] load,
  output logic      [3:0][7:0] vout_sense,
  output logic      [3:0][7:0] current_sense,
  output logic                 overlap
);
  always_comb
  begin
    for (int c = 0; c < 4; c++)
    begin
      // Ideal loop: output sits on the reference, 50 mV into 20 mV units
      vout_sense[c]    = 8'((int'(channel_ref[c]) * 5) / 2);
      // Drop across the low-side switch exists only while it conducts
      current_sense[c] = gate_low[c] ? load[c] : 8'h00;
    end
    // Both switches on would short the input
    overlap = |(gate_high & gate_low);
  end
endmodule

// ---- tb/buck_channel_pwm_bench.sv ----
// Self-checking bench for the four-channel buck sequencer and PWM.
// Assumes shortened counts: 2 clocks per us, 3 quarter-ms over-current wait.
`timescale 1ns/100ps
module buck_channel_pwm_bench;
  import buck_seq_pkg::*;
  localparam int CYC_US  = 2;
  localparam int OC_WAIT = 3;
  localparam int QCLK    = CYC_US * QUARTER_US;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic [3:0]       en = 4'h0;
  logic [3:0]       oc_clr = 4'h0;
  logic [3:0][15:0] rise, fall;
  logic [7:0]       sel, f_lo, f_hi;
  logic [3:0][7:0]  upper, lower, pgd, cap, limit, target, dis, demand, load;
  logic [3:0][7:0]  vs, cs, ref_o;
  logic [3:0]       gh, gl, pg, ocs;
  logic             overlap;
  int               n_fail = 0;
  int               samples_checked = 0;

  always #10 clk = ~clk;

  buck_channel_pwm #(.CYC_US(CYC_US), .OC_WAIT(OC_WAIT)) buck_channel_pwm_inst (
    .clk(clk), .rst_b(rst_b), .channel_enable(en), .channel_rise_profile(rise),
    .channel_fall_profile(fall), .switching_clock_select(sel),
    .good_window_upper(upper), .good_window_lower(lower), .good_assert_delay(pgd),
    .channel_duty_cap(cap), .follower_map_low(f_lo), .follower_map_high(f_hi),
    .current_limit_setting(limit), .vout_target(target), .discharge_level(dis),
    .duty_demand(demand), .vout_sense(vs), .current_sense(cs),
    .overcurrent_clear(oc_clr), .gate_high(gh), .gate_low(gl), .power_good(pg),
    .overcurrent_status(ocs), .channel_ref(ref_o));

  power_stage_model power_stage_model_inst (
    .gate_high(gh), .gate_low(gl), .channel_ref(ref_o), .load(load),
    .vout_sense(vs), .current_sense(cs), .overlap(overlap));

  task automatic check_val(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_range(input string what, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic wait_ref(input int c, input logic [7:0] v, output int t);
    for (t = 0; t < 4000 && ref_o[c] !== v; t++)
      @(negedge clk);
  endtask

  task automatic edges(input int c, input int n, output int k);
    logic prev;
    k = 0;
    prev = gh[c];
    repeat (n)
    begin
      @(negedge clk);
      if (gh[c] === 1'b1 && prev !== 1'b1)
        k++;
      prev = gh[c];
    end
  endtask

  task automatic pulse(input int c, output int hi, output int lo);
    int t;
    for (t = 0; t < 400 && gh[c] === 1'b1; t++)
      @(negedge clk);
    for (t = 0; t < 400 && gh[c] !== 1'b1; t++)
      @(negedge clk);
    for (hi = 0; hi < 400 && gh[c] === 1'b1; hi++)
      @(negedge clk);
    for (lo = 0; lo < 400 && gh[c] !== 1'b1; lo++)
      @(negedge clk);
  endtask

  task automatic t_start();
    int   t;
    logic quiet;
    quiet = 1'b1;
    en[1:0] = 2'b11;
    for (t = 0; t < 1200 && ref_o[1] === 8'h00; t++)
    begin
      @(negedge clk);
      quiet &= (gh[0] === 1'b0);
    end
    check_val("ch0 ref while ch1 rises", 16'h0000, ref_o[0]);
    check_val("ch0 gates in delay", 16'h0001, quiet);
    for (; t < 1200 && ref_o[0] === 8'h00; t++)
      @(negedge clk);
    check_range("ch0 start delay", QCLK, 2 * QCLK + 8, t);
    for (t = 0; t < 200 && ref_o[0] !== 8'h08; t++)
    begin
      @(negedge clk);
      quiet &= (pg[0] === 1'b0);
    end
    check_range("ch0 ramp 1 to 8", 41, 43, t);
    check_val("good during ramp", 16'h0001, quiet);
    for (t = 0; t < 1200 && pg[0] !== 1'b1; t++)
      @(negedge clk);
    check_range("good delay", QCLK, 2 * QCLK + 4, t);
    upper[0] = 8'd19;
    repeat (3) @(negedge clk);
    check_val("good above upper", 16'h0000, pg[0]);
    upper[0] = 8'd30;
    lower[0] = 8'd21;
    repeat (3) @(negedge clk);
    check_val("good below lower", 16'h0000, pg[0]);
    lower[0] = 8'd0;
    $display("test start done");
  endtask

  task automatic t_pwm();
    int k, hi, lo;
    logic [7:0] caps[4] = '{8'h78, 8'h40, 8'h78, 8'hFF};
    logic [7:0] dems[4] = '{8'hFF, 8'hFF, 8'h08, 8'hFF};
    int         ons[4]  = '{15, 8, 2, 16};
    for (int c = 0; c < 8; c++)
    begin
      sel = {1'b0, 3'(c), 4'h1};
      edges(0, 2000, k);
      check_range("pulses per osc code", 2000 * (480 - 32 * c) / 16000 - 1,
                  2000 * (480 - 32 * c) / 16000 + 1, k);
    end
    sel = 8'h03;
    edges(0, 2000, k);
    check_range("pulses div 3", 29, 31, k);
    sel = 8'h00;
    edges(0, 300, k);
    check_val("div 0 gates", 16'h0000, {k[7:0], gh, gl});
    sel = 8'h01;
    for (int i = 0; i < 4; i++)
    begin
      cap[0] = caps[i];
      demand[0] = dems[i];
      repeat (80) @(negedge clk);
      pulse(0, hi, lo);
      check_range("high width", ons[i], ons[i] + 1, hi);
      check_range("low width", 32 - ons[i], 34 - ons[i], lo);
    end
    cap[0] = 8'h78;
    demand[0] = 8'h80;
    $display("test pwm done");
  endtask

  task automatic t_oc();
    int t;
    load[0] = limit[0];
    repeat (200) @(negedge clk);
    check_val("no trip at limit", 16'h0000, ocs);
    load[0] = 8'h20;
    for (t = 0; t < 200 && cs[0] <= limit[0]; t++)
      @(negedge clk);
    repeat (2) @(negedge clk);
    check_val("ch0 gates after trip", 16'h0000, {gh[0], gl[0]});
    check_val("follower gates", 16'h0000, {gh[1], gl[1]});
    check_val("fault flags", 16'h0001, ocs);
    load[0] = 8'h0A;
    wait_ref(0, 8'h01, t);
    check_range("restart time", 3 * QCLK, 6 * QCLK + 20, t);
    check_val("follower restarted", 16'h0001, ref_o[1] != 8'h00);
    check_val("flag held", 16'h0001, ocs);
    oc_clr[0] = 1'b1;
    @(negedge clk);
    oc_clr[0] = 1'b0;
    @(negedge clk);
    check_val("flag cleared", 16'h0000, ocs);
    wait_ref(0, 8'h08, t);
    $display("test overcurrent done");
  endtask

  task automatic t_stop();
    int t, k;
    en[0] = 1'b0;
    edges(0, 400, k);
    check_range("pulses in stop delay", 10, 20, k);
    check_val("ref in stop delay", 16'h0008, ref_o[0]);
    check_val("good dropped", 16'h0000, pg[0]);
    wait_ref(0, 8'h07, t);
    wait_ref(0, 8'h03, t);
    check_range("ramp 7 to 3", 15, 17, t);
    wait_ref(0, 8'h02, t);
    repeat (4) @(negedge clk);
    edges(0, 300, k);
    check_val("gates after stop", 16'h0000, {k[7:0], gh[0], gl[0]});
    edges(1, 300, k);
    check_range("ch1 keeps running", 5, 20, k);
    check_val("no overlap", 16'h0000, overlap);
    $display("test stop done");
  endtask

  task automatic wrap_up();
    $display("Counts: %0d checked, %0d failed", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    $display("ERROR watchdog expected finish seen timeout");
    wrap_up();
  end

  initial
  begin
    rise = {16'h0000, 16'h0000, 16'h0401, 16'h0803};
    fall = {4{16'h0802}};
    // Internal oscillator only; no external clock to match
    sel = 8'h01;
    {f_hi, f_lo} = 16'h0002;
    upper = {4{8'd30}};
    lower = '0;
    pgd = {8'd1, 8'd1, 8'd1, 8'd2};
    cap = {4{8'h78}};
    limit = {4{8'h0D}};
    target = {8'd4, 8'd4, 8'd4, 8'd8};
    dis = {4{8'd2}};
    demand = {4{8'h80}};
    load = {4{8'h0A}};
    repeat (20) @(negedge clk);
    check_val("outputs in reset", 16'h0000, {gh, gl, pg, ocs});
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    check_val("refs after reset", 16'h0000, ref_o[1:0]);
    t_start();
    t_pwm();
    t_oc();
    t_stop();
    wrap_up();
  end
endmodule
